// ===== verilog/dsc_consts.vh
// Constants shared by the strobe capture physical layer files
`ifndef DSC_CONSTS_VH
`define DSC_CONSTS_VH

// ****************************************************************
// Bus modes and lane masks
// ****************************************************************
`define DSC_MODE_X8 2'h0
`define DSC_MODE_X16 2'h1
`define DSC_MODE_X32 2'h2
`define DSC_MASK_X8 32'h000000FF
`define DSC_MASK_X16 32'h0000FFFF
`define DSC_MASK_X32 32'hFFFFFFFF

// ****************************************************************
// Strobe groups per side (top or bottom)
// ****************************************************************
`define DSC_GROUPS_X8_SIDE 5'h0A
`define DSC_GROUPS_X16_SIDE 5'h04
`define DSC_GROUPS_X32_SIDE 5'h02

// ****************************************************************
// Phase shift: degrees, and fraction of a period in 1/256 units
// ****************************************************************
`define DSC_PHASE_DDR_DEG 90
`define DSC_PHASE_FCRAM_DEG 72
`define DSC_FRAC_DDR 8'h40
`define DSC_FRAC_FCRAM 8'h33
`define DSC_PHASE_DDR 1'b0
`define DSC_PHASE_FCRAM 1'b1

// ****************************************************************
// Timing counts
// ****************************************************************
`define DSC_LOCK_REF_CYCLES 9'h100
`define DSC_REF_TIMEOUT 8'hFF
`define DSC_TX_PERIOD 8'h08
`define DSC_TX_HALF 3'h4
`define DSC_TX_LAST 3'h7
`define DSC_TX_MID 3'h3
`define DSC_MAX_MHZ_DDR 200
`define DSC_MAX_MHZ_QDR 167

// ****************************************************************
// Write buffer shape
// ****************************************************************
`define DSC_FIFO_DEPTH 16
`define DSC_FIFO_AW 4
`define DSC_WORD_W 64

`endif

// ===== verilog/dsc_fifo.v
// Write data buffer with registered read data and valid/ready on both sides
`timescale 1ns/10ps
`default_nettype none

module dsc_fifo #(
  parameter WIDTH = 64,
  parameter DEPTH = 16,
  parameter AW = 4
) (
  input wire mclk,
  input wire sysRst,
  input wire inValid,
  output reg inReady,
  input wire [WIDTH-1:0] inData,
  output reg outValid,
  input wire outReady,
  output reg [WIDTH-1:0] outData
);

  // ****************************************************************
  // Storage and pointers
  // ****************************************************************
  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW-1:0] wrPtr_r;
  reg [AW-1:0] rdPtr_r;
  reg [AW:0] count_r;
  reg [AW:0] count_nxt;
  wire push;
  wire load;
  // Stored-word count at which the buffer refuses more
  localparam [AW:0] FULL_CNT = DEPTH;

  assign push = inValid & inReady;
  // Output register refills when empty or when drained this cycle
  assign load = (count_r != {(AW+1){1'b0}}) & (~outValid | outReady);

  always @* begin
    count_nxt = count_r;
    if (push & ~load) begin
      count_nxt = count_r + 1'b1;
    end else if (load & ~push) begin
      count_nxt = count_r - 1'b1;
    end
  end

  always @(posedge mclk) begin
    if (push) begin
      mem[wrPtr_r] <= inData;
    end
  end

  always @(posedge mclk) begin
    if (sysRst) begin
      wrPtr_r <= {AW{1'b0}};
      rdPtr_r <= {AW{1'b0}};
      count_r <= {(AW+1){1'b0}};
      inReady <= 1'b0;
      outValid <= 1'b0;
      outData <= {WIDTH{1'b0}};
    end else begin
      count_r <= count_nxt;
      // Registered ready: honest full, one cycle of margin never needed
      inReady <= (count_nxt != FULL_CNT);
      if (push) begin
        wrPtr_r <= wrPtr_r + 1'b1;
      end
      if (load) begin
        outData <= mem[rdPtr_r];
        rdPtr_r <= rdPtr_r + 1'b1;
        outValid <= 1'b1;
      end else if (outReady) begin
        outValid <= 1'b0;
      end
    end
  end

endmodule // dsc_fifo
`default_nettype wire

// ===== verilog/dsc_strobe_phy.v
// Strobe group capture and launch logic for double-rate memory pins
`timescale 1ns/10ps
`default_nettype none
`include "dsc_consts.vh"

module dsc_strobe_phy (
  input wire mclk,
  input wire sysRst,
  input wire [1:0] modeSel,
  input wire phaseSel,
  input wire [4:0] groupSel,
  input wire refClkPin,
  input wire dqsIn,
  input wire [31:0] dqIn,
  input wire wrValid,
  input wire [63:0] wrData,
  output wire wrReady,
  output reg [31:0] dqOut_r,
  output reg dqOeN_r,
  output reg dqsOut_r,
  output reg dqsOeN_r,
  output reg [63:0] rdData_r,
  output reg rdValid_r,
  output reg phaseLocked_r,
  output reg groupErr_r
);

  // ****************************************************************
  // Functions
  // ****************************************************************
  function [31:0] laneMask;
    input [1:0] mode;
    begin
      case (mode)
        `DSC_MODE_X8: laneMask = `DSC_MASK_X8;
        `DSC_MODE_X16: laneMask = `DSC_MASK_X16;
        `DSC_MODE_X32: laneMask = `DSC_MASK_X32;
        default: laneMask = 32'h00000000;
      endcase
    end
  endfunction

  function [4:0] sideGroups;
    input [1:0] mode;
    begin
      case (mode)
        `DSC_MODE_X8: sideGroups = `DSC_GROUPS_X8_SIDE;
        `DSC_MODE_X16: sideGroups = `DSC_GROUPS_X16_SIDE;
        `DSC_MODE_X32: sideGroups = `DSC_GROUPS_X32_SIDE;
        default: sideGroups = 5'h00;
      endcase
    end
  endfunction

  // Fraction of a period; rounds down so the edge never lands late
  function [7:0] phaseDelay;
    input [7:0] period;
    input sel;
    reg [15:0] prod;
    begin
      prod = period * (sel ? `DSC_FRAC_FCRAM : `DSC_FRAC_DDR);
      phaseDelay = prod[15:8];
    end
  endfunction

  // ****************************************************************
  // Pin synchronisers
  // ****************************************************************
  reg refS1_r;
  reg refS2_r;
  reg refPrev_r;
  reg dqsS1_r;
  reg dqsS2_r;
  reg dqsPrev_r;
  reg [31:0] dqS1_r;
  reg [31:0] dqS2_r;

  always @(posedge mclk) begin
    if (sysRst) begin
      refS1_r <= 1'b0;
      refS2_r <= 1'b0;
      refPrev_r <= 1'b0;
      dqsS1_r <= 1'b0;
      dqsS2_r <= 1'b0;
      dqsPrev_r <= 1'b0;
      dqS1_r <= 32'h00000000;
      dqS2_r <= 32'h00000000;
    end else begin
      refS1_r <= refClkPin;
      refS2_r <= refS1_r;
      refPrev_r <= refS2_r;
      dqsS1_r <= dqsIn;
      dqsS2_r <= dqsS1_r;
      dqsPrev_r <= dqsS2_r;
      // Data and strobe take equal stages so their skew is kept
      dqS1_r <= dqIn;
      dqS2_r <= dqS1_r;
    end
  end

  wire refRise;
  wire dqsRise;
  wire dqsFall;
  wire [31:0] mask;
  wire groupOk;

  assign refRise = refS2_r & ~refPrev_r;
  assign dqsRise = dqsS2_r & ~dqsPrev_r;
  assign dqsFall = ~dqsS2_r & dqsPrev_r;
  assign mask = laneMask(modeSel);
  assign groupOk = (groupSel < sideGroups(modeSel));

  // ****************************************************************
  // Phase reference: period measure and lock
  // ****************************************************************
  reg [7:0] refCnt_r;
  reg [7:0] refPeriod_r;
  reg [8:0] lockCnt_r;
  reg phaseSelPrev_r;

  always @(posedge mclk) begin
    if (sysRst) begin
      refCnt_r <= 8'h00;
      refPeriod_r <= 8'h00;
      lockCnt_r <= 9'h000;
      phaseLocked_r <= 1'b0;
      phaseSelPrev_r <= 1'b0;
    end else begin
      phaseSelPrev_r <= phaseSel;
      if (phaseSel != phaseSelPrev_r) begin
        // A new phase setting restarts the lock count; the period measure holds its count for that cycle
        lockCnt_r <= 9'h000;
        phaseLocked_r <= 1'b0;
      end else if (refRise) begin
        refCnt_r <= 8'h00;
        refPeriod_r <= refCnt_r + 8'h01;
        if (lockCnt_r == `DSC_LOCK_REF_CYCLES - 9'h001) begin
          phaseLocked_r <= 1'b1;
        end else begin
          lockCnt_r <= lockCnt_r + 9'h001;
        end
      end else if (refCnt_r == `DSC_REF_TIMEOUT) begin
        // Stopped reference clock: the delay can no longer be trusted
        lockCnt_r <= 9'h000;
        phaseLocked_r <= 1'b0;
      end else begin
        refCnt_r <= refCnt_r + 8'h01;
      end
    end
  end

  // ****************************************************************
  // Strobe delay and double-rate capture
  // ****************************************************************
  reg [7:0] dlyCnt_r;
  reg dlyArm_r;
  reg dlyFall_r;
  reg [31:0] riseBits_r;
  wire [7:0] rxDelay;
  wire rxEnable;

  assign rxDelay = phaseDelay(refPeriod_r, phaseSel);
  // Own driving blocks capture, but with the DDR phase the own strobe's last fall is sampled in the first cycle after release
  assign rxEnable = phaseLocked_r & groupOk & dqOeN_r;

  always @(posedge mclk) begin
    if (sysRst) begin
      dlyCnt_r <= 8'h00;
      dlyArm_r <= 1'b0;
      dlyFall_r <= 1'b0;
      riseBits_r <= 32'h00000000;
      rdData_r <= 64'h0000000000000000;
      rdValid_r <= 1'b0;
    end else begin
      rdValid_r <= 1'b0;
      if ((dqsRise | dqsFall) & rxEnable) begin
        dlyCnt_r <= rxDelay;
        dlyArm_r <= 1'b1;
        dlyFall_r <= dqsFall;
      end else if (dlyArm_r & (dlyCnt_r != 8'h00)) begin
        dlyCnt_r <= dlyCnt_r - 8'h01;
      end else if (dlyArm_r) begin
        dlyArm_r <= 1'b0;
        if (!dlyFall_r) begin
          riseBits_r <= dqS2_r & mask;
        end else begin
          // Held first bit pairs with the second on one edge
          rdData_r <= {dqS2_r & mask, riseBits_r};
          rdValid_r <= phaseLocked_r;
        end
      end
    end
  end

  // ****************************************************************
  // Write buffer
  // ****************************************************************
  wire [63:0] txWord;
  wire txValid;
  wire txPop;
  reg txArm_r;

  dsc_fifo #(
    .WIDTH(`DSC_WORD_W),
    .DEPTH(`DSC_FIFO_DEPTH),
    .AW(`DSC_FIFO_AW)
  ) uWrFifo (
    .mclk(mclk),
    .sysRst(sysRst),
    .inValid(wrValid),
    .inReady(wrReady),
    .inData(wrData),
    .outValid(txValid),
    .outReady(txPop),
    .outData(txWord)
  );

  // ****************************************************************
  // Double-rate launch
  // ****************************************************************
  reg [2:0] txPhase_r;
  reg [31:0] txFall_r;
  reg txLive_r;
  wire [7:0] txShiftFull;
  wire [2:0] txShift;
  wire [2:0] txRel;

  assign txPop = (txPhase_r == `DSC_TX_LAST) & txArm_r;
  assign txShiftFull = phaseDelay(`DSC_TX_PERIOD, phaseSel);
  // Shift is under one launch period, so three bits always hold it
  assign txShift = txShiftFull[2:0];
  assign txRel = txPhase_r + 3'h1 - txShift;

  always @(posedge mclk) begin
    if (sysRst) begin
      txPhase_r <= 3'h0;
      txFall_r <= 32'h00000000;
      txArm_r <= 1'b0;
      txLive_r <= 1'b0;
      dqOut_r <= 32'h00000000;
      dqOeN_r <= 1'b1;
      dqsOut_r <= 1'b0;
      dqsOeN_r <= 1'b1;
      groupErr_r <= 1'b0;
    end else begin
      txPhase_r <= txPhase_r + 3'h1;
      groupErr_r <= ~groupOk;
      if (txPhase_r == `DSC_TX_MID) begin
        // Enable turns on only at the falling edge of the launch clock; it is released at the rising edge
        if (txValid & groupOk) begin
          txArm_r <= 1'b1;
          dqOeN_r <= 1'b0;
          dqsOeN_r <= 1'b0;
        end else begin
          txArm_r <= 1'b0;
        end
        dqOut_r <= txFall_r;
      end else if (txPhase_r == `DSC_TX_LAST) begin
        if (txArm_r) begin
          dqOut_r <= txWord[31:0] & mask;
          txFall_r <= txWord[63:32] & mask;
          txLive_r <= 1'b1;
        end else begin
          // Back-to-back words keep the bus driven with no idle gap
          dqOeN_r <= 1'b1;
          dqsOeN_r <= 1'b1;
          txLive_r <= 1'b0;
        end
      end
      // Strobe stays low in the preamble, then runs shifted
      if (txLive_r | txPop) begin
        dqsOut_r <= (txRel < `DSC_TX_HALF);
      end else begin
        dqsOut_r <= 1'b0;
      end
    end
  end

endmodule // dsc_strobe_phy
`default_nettype wire

// ===== dv/dsc_strobe_phy_assertions.sv
// Port checker for the strobe capture physical layer
`timescale 1ns/10ps
`default_nettype none
`include "dsc_consts.vh"
module dsc_strobe_phy_assertions (
  input wire logic mclk,
  input wire logic sysRst,
  input wire logic [1:0] modeSel,
  input wire logic phaseSel,
  input wire logic [4:0] groupSel,
  input wire logic refClkPin,
  input wire logic [31:0] dqOut_r,
  input wire logic dqOeN_r,
  input wire logic dqsOut_r,
  input wire logic dqsOeN_r,
  input wire logic [63:0] rdData_r,
  input wire logic rdValid_r,
  input wire logic phaseLocked_r,
  input wire logic groupErr_r
);
  // ****************************************************************
  // Raw reference edge count, runs slightly ahead of the synced one
  // ****************************************************************
  logic refPrev_r;
  logic phasePrev_r;
  logic [8:0] refCnt_r;
  logic [4:0] limit;
  logic badGrp;
  assign limit = (modeSel == `DSC_MODE_X8) ? `DSC_GROUPS_X8_SIDE :
    (modeSel == `DSC_MODE_X16) ? `DSC_GROUPS_X16_SIDE : `DSC_GROUPS_X32_SIDE;
  assign badGrp = (modeSel == 2'h3) || (groupSel >= limit);
  always_ff @(posedge mclk) begin
    refPrev_r <= refClkPin;
    phasePrev_r <= phaseSel;
    if (sysRst || phaseSel != phasePrev_r) begin
      refCnt_r <= 9'h000;
    end else if (refClkPin && !refPrev_r && refCnt_r != 9'h12C) begin
      refCnt_r <= refCnt_r + 9'h001;
    end
  end
  default clocking cb @(posedge mclk); endclocking
  default disable iff (sysRst);
  a_lock_early: assert property (
    $rose(phaseLocked_r) |-> refCnt_r >= 9'h0FE) else $error("early lock");
  a_lock_late: assert property (
    refCnt_r == 9'h104 |-> phaseLocked_r) else $error("late lock");
  a_phase_relock: assert property (
    $changed(phaseSel) |-> ##2 !phaseLocked_r [*6]) else $error("lock kept");
  a_oe_pair: assert property (
    dqOeN_r == dqsOeN_r) else $error("enables differ");
  a_oe_span: assert property (
    $fell(dqOeN_r) |-> ##4 !dqOeN_r [*8]) else $error("enable too short");
  a_dqs_pulse: assert property (
    $rose(dqsOut_r) |-> dqsOut_r [*4] ##1 !dqsOut_r) else $error("bad strobe");
  a_lane_x16: assert property (
    !dqOeN_r && modeSel == `DSC_MODE_X16 |-> dqOut_r[31:16] == 16'h0000)
    else $error("upper lanes driven");
  a_rd_mask: assert property (
    rdValid_r && modeSel == `DSC_MODE_X8 |->
    rdData_r[63:40] == 24'h0 && rdData_r[31:8] == 24'h0)
    else $error("read lanes unmasked");
  a_rd_gate: assert property (
    rdValid_r |-> phaseLocked_r && dqOeN_r && !groupErr_r ##1 !rdValid_r)
    else $error("read not allowed");
  a_group_flag: assert property (
    !$past(sysRst) |-> groupErr_r == $past(badGrp)) else $error("group flag");
  c_lock: cover property ($rose(phaseLocked_r));
  c_read: cover property (rdValid_r);
  c_write: cover property ($fell(dqOeN_r));
endmodule // dsc_strobe_phy_assertions
bind dsc_strobe_phy dsc_strobe_phy_assertions u_dsc_strobe_phy_assertions (
  .mclk, .sysRst, .modeSel, .phaseSel, .groupSel, .refClkPin, .dqOut_r,
  .dqOeN_r, .dqsOut_r, .dqsOeN_r, .rdData_r, .rdValid_r, .phaseLocked_r,
  .groupErr_r);
`default_nettype wire

// ===== dv/dsc_mem_model.sv
// Behavioural memory device: reference clock and read strobe bursts
`timescale 1ns/10ps
`default_nettype none
module dsc_mem_model (
  output logic refClk,
  output logic dqs,
  output logic [31:0] dq
);
  initial begin
    refClk = 1'b0;
    dqs = 1'b0;
    dq = 32'h00000000;
  end
  // Free-running, same rate as the strobe
  always #40 refClk = ~refClk;
  // Edge-aligned pair; strobe idles low, released data is inverted
  // Only the last pair of a burst releases the data lines
  task automatic sendPair(input logic [31:0] a, input logic [31:0] b,
    input logic last);
    dqs = 1'b1;
    dq = a;
    #40;
    dqs = 1'b0;
    dq = b;
    #40;
    if (last)
      dq = ~b;
  endtask
endmodule // dsc_mem_model
`default_nettype wire

// ===== dv/dsc_strobe_phy_test.sv
// Self-checking bench for the strobe capture physical layer
`timescale 1ns/10ps
`default_nettype none
`include "dsc_consts.vh"
module dsc_strobe_phy_test;
  logic mclk = 1'b0;
  logic sysRst = 1'b1;
  logic [1:0] modeSel = 2'h0;
  logic phaseSel = 1'b0;
  logic [4:0] groupSel = 5'h00;
  logic wrValid = 1'b0;
  logic [63:0] wrData = 64'h0;
  wire logic refClk, memDqs, wrReady, dqOeN_r, dqsOut_r, dqsOeN_r;
  wire logic rdValid_r, phaseLocked_r, groupErr_r;
  wire logic [31:0] memDq, dqOut_r;
  wire logic [63:0] rdData_r;
  wire logic [31:0] dqPin = dqOeN_r ? memDq : dqOut_r;
  wire logic dqsPin = dqsOeN_r ? memDqs : dqsOut_r;
  int numErrors = 0;
  int checksDone = 0;
  int cycles = 0;
  logic [31:0] seed = 32'h00000061;
  logic [31:0] a, b;
  logic [63:0] w;
  logic full = 1'b0;
  logic bad;
  logic [4:0] lims [4] = '{`DSC_GROUPS_X8_SIDE, `DSC_GROUPS_X16_SIDE,
    `DSC_GROUPS_X32_SIDE, 5'h01};
  logic [63:0] rdQ [$];
  logic [63:0] wrQ [$];
  always #5 mclk = ~mclk;
  dsc_strobe_phy u_dsc_strobe_phy (.mclk, .sysRst, .modeSel, .phaseSel,
    .groupSel, .refClkPin(refClk), .dqsIn(dqsPin), .dqIn(dqPin), .wrValid,
    .wrData, .wrReady, .dqOut_r, .dqOeN_r, .dqsOut_r, .dqsOeN_r, .rdData_r,
    .rdValid_r, .phaseLocked_r, .groupErr_r);
  dsc_mem_model u_dsc_mem_model (.refClk(refClk), .dqs(memDqs), .dq(memDq));
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  function automatic logic [31:0] maskOf(input logic [1:0] m);
    return (m == `DSC_MODE_X8) ? `DSC_MASK_X8 :
      (m == `DSC_MODE_X16) ? `DSC_MASK_X16 : `DSC_MASK_X32;
  endfunction
  task automatic cmpData(input logic [63:0] got, input logic [63:0] exp,
    input string what);
    checksDone++;
    if (got !== exp) begin
      numErrors++;
      $display("Error %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask
  task automatic cmpFlag(input logic got, input logic exp, input string what);
    cmpData({63'h0, got}, {63'h0, exp}, what);
  endtask
  task automatic summarize();
    if (numErrors == 0 && checksDone > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  task automatic waitLock();
    for (int i = 0; i < 2400 && phaseLocked_r !== 1'b1; i++)
      @(posedge mclk);
    cmpFlag(phaseLocked_r, 1'b1, "phase lock");
  endtask
  task automatic relock(input logic p);
    phaseSel <= p;
    repeat (3) @(posedge mclk);
    cmpFlag(phaseLocked_r, 1'b0, "lock after phase change");
    waitLock();
  endtask
  task automatic readPairs(input logic [1:0] m);
    modeSel <= m;
    repeat (4) @(posedge mclk);
    #3;
    for (int i = 0; i < 3; i++) begin
      a = rnd();
      b = rnd();
      rdQ.push_back({b & maskOf(m), a & maskOf(m)});
      u_dsc_mem_model.sendPair(a, b, i == 2);
    end
    repeat (12) @(posedge mclk);
  endtask
  task automatic writeWords(input int n);
    for (int i = 0; i < n; i++) begin
      w = {rnd(), rnd()};
      wrValid <= 1'b1;
      wrData <= w;
      @(posedge mclk);
      while (wrReady !== 1'b1) begin
        full = 1'b1;
        @(posedge mclk);
      end
      wrQ.push_back({32'h0, w[31:0] & maskOf(modeSel)});
      wrQ.push_back({32'h0, w[63:32] & maskOf(modeSel)});
    end
    wrValid <= 1'b0;
    for (int i = 0; i < 400 && wrQ.size() != 0; i++)
      @(posedge mclk);
    cmpFlag(wrQ.size() == 0, 1'b1, "write drain");
  endtask
  // ****************************************************************
  // Monitors: oldest note is compared against each result
  // ****************************************************************
  always @(posedge mclk) begin
    cycles++;
    if (cycles == 10000) begin
      numErrors++;
      summarize();
    end else if (rdValid_r === 1'b1) begin
      if (rdQ.size() == 0) begin
        numErrors++;
        $display("Error %0t: read word without strobe pair", $time);
      end else
        cmpData(rdData_r, rdQ.pop_front(), "read pair");
    end
  end
  // Skips the stale half launched as the enable falls
  initial forever begin
    @(negedge dqOeN_r);
    repeat (6) @(posedge mclk);
    while (dqOeN_r === 1'b0) begin
      cmpData({32'h0, dqOut_r}, wrQ.pop_front(), "first half");
      // Phase 1 of the period: high only with the shorter shift
      cmpFlag(dqsOut_r, phaseSel == `DSC_PHASE_FCRAM, "strobe lead");
      repeat (4) @(posedge mclk);
      cmpData({32'h0, dqOut_r}, wrQ.pop_front(), "second half");
      cmpFlag(dqsOut_r, phaseSel == `DSC_PHASE_DDR, "strobe lag");
      repeat (4) @(posedge mclk);
    end
  end
  // ****************************************************************
  // Main sequence
  // ****************************************************************
  initial begin
    repeat (3) @(posedge mclk);
    cmpData({25'h0, dqOut_r, dqOeN_r, dqsOeN_r, dqsOut_r, rdValid_r,
      phaseLocked_r, groupErr_r, wrReady}, 64'h60, "reset state");
    sysRst <= 1'b0;
    waitLock();
    relock(`DSC_PHASE_FCRAM);
    for (int m = 0; m < 3; m++)
      readPairs(m[1:0]);
    for (int m = 0; m < 4; m++) begin
      for (int g = 0; g < 2; g++) begin
        @(posedge mclk);
        bad = (m == 3) || (g == 1);
        modeSel <= m[1:0];
        groupSel <= lims[m] - 5'h01 + g[4:0];
        repeat (3) @(posedge mclk);
        cmpFlag(groupErr_r, bad, "group range");
        if (bad) begin
          #3;
          u_dsc_mem_model.sendPair(rnd(), rnd(), 1'b1);
          repeat (8) @(posedge mclk);
        end
      end
    end
    modeSel <= `DSC_MODE_X16;
    groupSel <= 5'h00;
    repeat (2) @(posedge mclk);
    writeWords(24);
    cmpFlag(full, 1'b1, "buffer refusal");
    // Longer shift: relock, then one read burst and one write burst
    relock(`DSC_PHASE_DDR);
    readPairs(`DSC_MODE_X32);
    writeWords(3);
    cmpFlag(rdQ.size() == 0, 1'b1, "reads all seen");
    summarize();
  end
endmodule // dsc_strobe_phy_test
`default_nettype wire
